// *** logic/precomp_chain.sv ***
// Purpose: precompensation filter chain between waveform source and DAC
// Assumes: mclk is the filter clock, one eighth of the sample rate
// Notes: each stage saturates to full scale and flags the saturation
// Operation
// - Filter clock is sample rate over eight; full chain base latency nine cycles.
// - Each stage adds its fixed latency only while enabled.
// - Each stage flags arithmetic overflow, registered one cycle after it occurs.
// - Each enabled stage also flags chain output hitting converter maximum or minimum.
// - Output limited to converter full scale; excess counts as converter overflow.
// - Recursive stages compute weighted inputs minus weighted past outputs, a0 one.
// - High-pass stage uses b0, b1 with a1 fixed at minus one.
// - Exponential stages use supplied b0, b1 and a1 coefficients.
// - Bounce stage adds amplitude times input delayed by d samples.
// - FIR has 72 taps; first eight free, later taps share pairwise coefficients.
// - Clear together with the playback condition picked by clear mode (level: playback high) wipes all filter history.
// - Order is eight exponential, high-pass, bounce, then FIR.
// - Enabled high-pass stage adds twelve cycles.
// - Enabled exponential stage adds eleven cycles.
// - Clear mode picks level, rise, fall or both edges of playback.
`timescale 1ns/10ps
`include "precomp_consts.svh"

// ****************************************
// Input FIFO
// ****************************************
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Fill side
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // Drain side
  output logic [WIDTH-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wp_reg;
  logic [AW:0] rp_reg;
  wire full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  wire push = wr_valid && !full;
  wire pop = rd_valid && rd_ready;
  assign wr_ready = !full;
  assign rd_valid = wp_reg != rp_reg;
  assign rd_data = mem[rp_reg[AW-1:0]];
  // Cleared so an empty read never feeds unknowns into the stages
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      for (int j = 0; j < DEPTH; j++)
        mem[j] <= '0;
    end
    else if (push)
      mem[wp_reg[AW-1:0]] <= wr_data;
  end
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
    end
    else
    begin
      if (push)
        wp_reg <= wp_reg + 1'b1;
      if (pop)
        rp_reg <= rp_reg + 1'b1;
    end
  end
endmodule : sync_fifo

// ****************************************
// Stage latency line
// ****************************************
module word_delay #(
  parameter int LEN = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic step,
  // Stream
  input wire precomp_pkg::word_t in_word,
  input wire logic in_vld,
  output precomp_pkg::word_t out_word,
  output logic out_vld
);
  import precomp_pkg::*;
  word_t d_reg [0:LEN-1];
  logic v_reg [0:LEN-1];
  assign out_word = d_reg[LEN-1];
  assign out_vld = v_reg[LEN-1];
  always_ff @(posedge mclk)
  begin
    for (int j = 0; j < LEN; j++)
    begin
      if (sys_rst)
      begin
        d_reg[j] <= '0;
        v_reg[j] <= 1'b0;
      end
      else if (step)
      begin
        d_reg[j] <= (j == 0) ? in_word : d_reg[(j == 0) ? 0 : j - 1];
        v_reg[j] <= (j == 0) ? in_vld : v_reg[(j == 0) ? 0 : j - 1];
      end
    end
  end
endmodule : word_delay

// ****************************************
// Filter chain
// ****************************************
module precomp_chain (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Upstream samples
  input wire precomp_pkg::word_t in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Sequencer
  input wire logic filter_clear_instruction,
  input wire logic waveform_playback_instruction,
  input wire precomp_pkg::clear_mode_t clear_mode,
  // Configuration
  input wire logic chain_en,
  input wire logic [`N_STAGE-1:0] stage_en,
  input wire precomp_pkg::coef_t [`N_EXP:0] iir_b0,
  input wire precomp_pkg::coef_t [`N_EXP:0] iir_b1,
  input wire precomp_pkg::coef_t [`N_EXP-1:0] exp_a1,
  input wire precomp_pkg::coef_t bounce_amp,
  input wire logic [7:0] bounce_dly,
  input wire precomp_pkg::coef_t [`FIR_COEFS-1:0] fir_coef,
  // Downstream
  output precomp_pkg::word_t out_data,
  output logic out_valid,
  input wire logic out_ready,
  // Status
  output logic [`N_STAGE-1:0] arith_ovf,
  output logic [`N_STAGE-1:0] dac_ovf
);
  import precomp_pkg::*;

  // Saturate a Q.30 sum to a sample, flag in the top bit
  function automatic logic [`SMP_W:0] limit(input logic signed [41:0] acc);
    logic signed [41:0] q;
    q = acc >>> `COEF_FRAC;
    if (q > $signed(42'h00000007fff))
      limit = {1'b1, `SMP_MAX};
    else if (q < $signed(42'h3ffffff8000))
      limit = {1'b1, `SMP_MIN};
    else
      limit = {1'b0, q[`SMP_W-1:0]};
  endfunction : limit

  function automatic logic at_lim(input word_t w);
    at_lim = 1'b0;
    for (int i = 0; i < `LANES; i++)
      at_lim = at_lim | (w[i*`SMP_W +: `SMP_W] == `SMP_MAX)
        | (w[i*`SMP_W +: `SMP_W] == `SMP_MIN);
  endfunction : at_lim

  word_t fifo_word;
  logic fifo_vld;
  word_t s_word [0:`ST_FIR];
  logic s_vld [0:`ST_FIR];
  logic [`N_STAGE-1:0] stage_sat;
  logic [`N_STAGE-1:0] arith_ovf_reg;
  logic [`N_STAGE-1:0] dac_ovf_reg;
  word_t out_data_reg;
  logic out_valid_reg;
  logic play_q;
  word_t b_word;
  logic b_vld;

  // Whole pipeline stalls with the DAC; the FIFO absorbs the upstream
  wire step = out_ready;
  wire [`N_STAGE-1:0] en = stage_en & {`N_STAGE{chain_en}};
  wire play = waveform_playback_instruction;
  wire rise = play && !play_q;
  wire fall = !play && play_q;
  wire clear_sel = (clear_mode == CLR_LEVEL) ? play :
    (clear_mode == CLR_RISE) ? rise :
    (clear_mode == CLR_FALL) ? fall : (rise || fall);
  wire clear = filter_clear_instruction && clear_sel;

  sync_fifo #(.WIDTH(`WORD_W), .DEPTH(`FIFO_DEPTH)) in_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wr_data(in_data),
    .wr_valid(in_valid),
    .wr_ready(in_ready),
    .rd_data(fifo_word),
    .rd_valid(fifo_vld),
    .rd_ready(step)
  );
  assign s_word[0] = fifo_word;
  assign s_vld[0] = fifo_vld;

  // ****************************************
  // Exponential, high-pass and bounce stages
  // ****************************************
  for (genvar k = 0; k <= `ST_BNC; k++)
  begin : g_stage
    localparam int L = (k < `N_EXP) ? `LAT_EXP : (k == `ST_HP) ? `LAT_HP : `LAT_BNC;
    word_t fw;
    logic fsat;
    word_t d_word;
    logic d_vld;
    if (k <= `ST_HP)
    begin : g_iir
      sample_t xp_reg;
      sample_t yp_reg;
      sample_t xi;
      sample_t xo;
      sample_t yo;
      coef_t a1;
      logic signed [41:0] acc;
      logic [`SMP_W:0] lim;
      if (k == `ST_HP)
      begin : g_hp
        assign a1 = `A1_HP;
      end
      else
      begin : g_exp
        assign a1 = exp_a1[k];
      end
      always_comb
      begin
        xo = xp_reg;
        yo = yp_reg;
        fsat = 1'b0;
        fw = '0;
        xi = '0;
        acc = '0;
        lim = '0;
        for (int i = 0; i < `LANES; i++)
        begin
          xi = s_word[k][i*`SMP_W +: `SMP_W];
          acc = 42'($signed(iir_b0[k]) * xi) + 42'($signed(iir_b1[k]) * xo)
            - 42'(a1 * yo);
          lim = limit(acc);
          fsat = fsat | lim[`SMP_W];
          yo = lim[`SMP_W-1:0];
          xo = xi;
          fw[i*`SMP_W +: `SMP_W] = yo;
        end
      end
      always_ff @(posedge mclk)
      begin
        if (sys_rst || clear)
        begin
          xp_reg <= '0;
          yp_reg <= '0;
        end
        else if (step && s_vld[k] && en[k])
        begin
          xp_reg <= xo;
          yp_reg <= yo;
        end
      end
    end
    else
    begin : g_bnc
      // Depth covers the longest delay of 255 samples
      word_t bh_reg [0:`BNC_HIST-1];
      logic [(`BNC_HIST+1)*`WORD_W-1:0] bflat;
      sample_t xi;
      sample_t xd;
      logic [`SMP_W:0] lim;
      always_comb
      begin
        bflat = '0;
        bflat[`BNC_HIST*`WORD_W +: `WORD_W] = s_word[k];
        for (int m = 0; m < `BNC_HIST; m++)
          bflat[(`BNC_HIST-1-m)*`WORD_W +: `WORD_W] = bh_reg[m];
      end
      always_comb
      begin
        fsat = 1'b0;
        fw = '0;
        xi = '0;
        xd = '0;
        lim = '0;
        for (int i = 0; i < `LANES; i++)
        begin
          xi = bflat[(`BNC_HIST*`LANES+i)*`SMP_W +: `SMP_W];
          xd = bflat[(`BNC_HIST*`LANES+i-int'(bounce_dly))*`SMP_W +: `SMP_W];
          lim = limit((42'(xi) <<< `COEF_FRAC) + 42'(bounce_amp * xd));
          fsat = fsat | lim[`SMP_W];
          fw[i*`SMP_W +: `SMP_W] = lim[`SMP_W-1:0];
        end
      end
      always_ff @(posedge mclk)
      begin
        for (int m = 0; m < `BNC_HIST; m++)
        begin
          if (sys_rst || clear)
            bh_reg[m] <= '0;
          else if (step && s_vld[k] && en[k])
            bh_reg[m] <= (m == 0) ? s_word[k] : bh_reg[(m == 0) ? 0 : m - 1];
        end
      end
    end
    // Valid enters only while enabled, so an enabled stage never replays old words
    word_delay #(.LEN(L)) dl (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .step(step),
      .in_word(fw),
      .in_vld(s_vld[k] && en[k]),
      .out_word(d_word),
      .out_vld(d_vld)
    );
    assign s_word[k+1] = en[k] ? d_word : s_word[k];
    assign s_vld[k+1] = en[k] ? d_vld : s_vld[k];
    assign stage_sat[k] = en[k] && s_vld[k] && fsat;
  end

  // ****************************************
  // FIR stage and output
  // ****************************************
  word_t fh_reg [0:`FIR_HIST-1];
  logic [(`FIR_HIST+1)*`WORD_W-1:0] fflat;
  word_t fir_word;
  logic fir_sat;
  logic signed [41:0] facc;
  coef_t fc;
  logic [`SMP_W:0] flim;
  always_comb
  begin
    fflat = '0;
    fflat[`FIR_HIST*`WORD_W +: `WORD_W] = s_word[`ST_FIR];
    for (int m = 0; m < `FIR_HIST; m++)
      fflat[(`FIR_HIST-1-m)*`WORD_W +: `WORD_W] = fh_reg[m];
  end
  always_comb
  begin
    fir_word = '0;
    fir_sat = 1'b0;
    facc = '0;
    fc = '0;
    flim = '0;
    for (int i = 0; i < `LANES; i++)
    begin
      facc = '0;
      for (int t = 0; t < `FIR_TAPS; t++)
      begin
        fc = (t < `FIR_FREE) ? fir_coef[t] : fir_coef[`FIR_FREE + (t - `FIR_FREE) / 2];
        facc = facc + 42'(fc * $signed(fflat[(`FIR_HIST*`LANES+i-t)*`SMP_W +: `SMP_W]));
      end
      flim = limit(facc);
      fir_sat = fir_sat | flim[`SMP_W];
      fir_word[i*`SMP_W +: `SMP_W] = flim[`SMP_W-1:0];
    end
  end
  always_ff @(posedge mclk)
  begin
    for (int m = 0; m < `FIR_HIST; m++)
    begin
      if (sys_rst || clear)
        fh_reg[m] <= '0;
      else if (step && s_vld[`ST_FIR] && en[`ST_FIR])
        fh_reg[m] <= (m == 0) ? s_word[`ST_FIR] : fh_reg[(m == 0) ? 0 : m - 1];
    end
  end
  assign stage_sat[`ST_FIR] = en[`ST_FIR] && s_vld[`ST_FIR] && fir_sat;

  // FIR carries no extra delay; it sits inside the base pipeline
  // Bypass keeps valids out of the line, else words repeat on enable
  word_delay #(.LEN(`LAT_BASE - 1)) base_dl (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .step(step),
    .in_word(en[`ST_FIR] ? fir_word : s_word[`ST_FIR]),
    .in_vld(s_vld[`ST_FIR] && chain_en),
    .out_word(b_word),
    .out_vld(b_vld)
  );
  wire word_t out_next = chain_en ? b_word : fifo_word;
  wire out_vld_next = chain_en ? b_vld : fifo_vld;
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      out_data_reg <= '0;
      out_valid_reg <= 1'b0;
      dac_ovf_reg <= '0;
      arith_ovf_reg <= '0;
      play_q <= 1'b0;
    end
    else
    begin
      play_q <= play;
      arith_ovf_reg <= stage_sat;
      if (step)
      begin
        out_data_reg <= out_next;
        out_valid_reg <= out_vld_next;
        dac_ovf_reg <= en & {`N_STAGE{out_vld_next && at_lim(out_next)}};
      end
    end
  end
  assign out_data = out_data_reg;
  assign out_valid = out_valid_reg;
  assign arith_ovf = arith_ovf_reg;
  assign dac_ovf = dac_ovf_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  logic [`N_STAGE-1:0] en_q;
  logic [5:0] run_cnt;
  always_ff @(posedge mclk)
  begin
    en_q <= stage_en;
    if (sys_rst || !(out_ready && chain_en && stage_en == en_q))
      run_cnt <= '0;
    else if (run_cnt != 6'h3f)
      run_cnt <= run_cnt + 6'h01;
  end
  wire bare = chain_en && stage_en == '0;
  base_lat_a: assert property ((step && fifo_vld && bare) ##1 (out_ready && bare)[*8]
    |=> out_data_reg == $past(fifo_word, 9)) else $error("base latency wrong");
  hp_lat_a: assert property (run_cnt >= 6'h16 && stage_en == 11'h100
    |-> out_valid_reg == $past(fifo_vld, 21)) else $error("high-pass latency wrong");
  exp_lat_a: assert property (run_cnt >= 6'h16 && stage_en == 11'h001
    |-> out_valid_reg == $past(fifo_vld, 20)) else $error("exponential latency wrong");
  bypass_pass_a: assert property (!chain_en && step
    |=> out_data_reg == $past(fifo_word)) else $error("bypass not transparent");
  dac_flag_a: assert property (dac_ovf_reg != '0
    |-> out_valid_reg && at_lim(out_data_reg)) else $error("converter flag without limit");
  flag_off_a: assert property ((arith_ovf_reg & ~$past(en)) == '0)
    else $error("flag from disabled stage");
  clear_state_a: assert property (clear |=> g_stage[0].g_iir.yp_reg == '0)
    else $error("clear left filter history");
  fall_clear_a: assert property ($fell(play) && filter_clear_instruction
    && clear_mode == CLR_FALL |-> clear) else $error("fall clear missed");
  level_clear_a: assert property (!play && clear_mode == CLR_LEVEL
    |-> !clear) else $error("level clear outside playback");
endmodule : precomp_chain

// *** logic/precomp_consts.svh ***
// Purpose: constants of the waveform precompensation chain
// Assumes: one filter-clock word carries eight samples
// Notes: coefficients are signed Q3.15, samples signed Q1.15
`ifndef PRECOMP_CONSTS_SVH
`define PRECOMP_CONSTS_SVH
`define LANES 8
`define SMP_W 16
`define WORD_W 128
`define COEF_W 18
`define COEF_FRAC 15
`define N_EXP 8
`define N_STAGE 11
`define ST_HP 8
`define ST_BNC 9
`define ST_FIR 10
`define LAT_BASE 9
`define LAT_EXP 11
`define LAT_HP 12
`define LAT_BNC 4
`define FIR_TAPS 72
`define FIR_FREE 8
`define FIR_COEFS 40
`define FIR_HIST 9
`define BNC_HIST 32
`define FIFO_DEPTH 16
`define A1_HP 18'h38000
`define SMP_MAX 16'h7fff
`define SMP_MIN 16'h8000
`endif

// *** logic/precomp_pkg.sv ***
// Purpose: shared types of the precompensation chain
// Assumes: constants come from the guarded header
// Notes: lane 0 is the oldest sample of a word
package precomp_pkg;
`include "precomp_consts.svh"
  typedef logic signed [`SMP_W-1:0] sample_t;
  typedef logic signed [`COEF_W-1:0] coef_t;
  typedef logic [`WORD_W-1:0] word_t;
  typedef enum logic [1:0] {
    CLR_LEVEL = 2'h0,
    CLR_RISE = 2'h1,
    CLR_FALL = 2'h2,
    CLR_BOTH = 2'h3
  } clear_mode_t;
endpackage : precomp_pkg

// *** verification/dac_sink.sv ***
// Purpose: converter-side sink model of the precompensation chain
// Assumes: out_ready is also the pipeline advance of the chain
// Notes: slow mode grants one cycle in three
`timescale 1ns/10ps

// ****************************************
// Converter sink
// ****************************************
module dac_sink (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Stream from chain
  input wire precomp_pkg::word_t out_data,
  input wire logic out_valid,
  output logic out_ready = 1'b0,
  // Pacing
  input wire logic hold,
  input wire logic slow
);
  import precomp_pkg::*;
  word_t rx_mem [0:255];
  int rx_count = 0;
  logic [1:0] phase_reg = 2'h0;
  // Ready moves off the sampling edge, so it never races the chain
  always @(negedge mclk)
  begin
    phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
    out_ready <= !hold && (!slow || phase_reg == 2'h0);
  end
  always @(posedge mclk)
  begin
    if (sys_rst)
      rx_count <= 0;
    else if (out_valid && out_ready)
    begin
      rx_mem[rx_count[7:0]] <= out_data;
      rx_count <= rx_count + 1;
    end
  end
endmodule : dac_sink

// *** verification/precomp_chain_test.sv ***
// Purpose: self-checking bench of the precompensation chain
// Assumes: unit-gain coefficients make every stage transparent
// Notes: latency is counted in edges from the edge that stores the word
`timescale 1ns/10ps
`include "precomp_consts.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module precomp_chain_test;
  import precomp_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  word_t in_data = '0;
  logic in_valid = 1'b0;
  logic in_ready;
  logic filter_clear_instruction = 1'b0;
  logic waveform_playback_instruction = 1'b0;
  clear_mode_t clear_mode = CLR_LEVEL;
  logic chain_en = 1'b0;
  logic [`N_STAGE-1:0] stage_en = '0;
  coef_t [`N_EXP:0] iir_b0;
  coef_t [`N_EXP:0] iir_b1;
  coef_t [`N_EXP-1:0] exp_a1;
  coef_t bounce_amp;
  logic [7:0] bounce_dly;
  coef_t [`FIR_COEFS-1:0] fir_coef;
  word_t out_data;
  logic out_valid;
  logic out_ready;
  logic [`N_STAGE-1:0] arith_ovf;
  logic [`N_STAGE-1:0] dac_ovf;
  logic [`N_STAGE-1:0] dac_seen;
  logic [`N_STAGE-1:0] ar_seen;
  logic hold = 1'b0;
  logic slow = 1'b0;
  int bad_count = 0;
  int checks_done = 0;
  word_t got;
  int lat;
  word_t unit_w = 128'h0008_0007_0006_0005_0004_0003_0002_0001;
  logic [11:0] cfg_tab [8] = '{12'h000, 12'h800, 12'h801, 12'h8ff, 12'h900, 12'ha00,
    12'hc00, 12'hfff};
  int lat_tab [8] = '{1, 9, 20, 97, 21, 13, 9, 113};

  precomp_chain u_dut (.mclk, .sys_rst, .in_data, .in_valid, .in_ready,
    .filter_clear_instruction, .waveform_playback_instruction, .clear_mode, .chain_en,
    .stage_en, .iir_b0, .iir_b1, .exp_a1, .bounce_amp, .bounce_dly, .fir_coef,
    .out_data, .out_valid, .out_ready, .arith_ovf, .dac_ovf);
  dac_sink u_dac (.mclk, .sys_rst, .out_data, .out_valid, .out_ready, .hold, .slow);

  initial
  begin
    forever #25 mclk = ~mclk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic word_t fill(logic [15:0] s);
    return {8{s}};
  endfunction : fill

  function automatic word_t ramp(int s);
    word_t w;
    for (int i = 0; i < 8; i++)
      w[16*i +: 16] = 16'((s + i + 1) * 256);
    return w;
  endfunction : ramp

  task report_and_stop;
    $display("TB: checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task set_unity;
    iir_b0 = {(`N_EXP+1){18'h08000}};
    iir_b1 = '0;
    iir_b1[`ST_HP] = 18'h38000;
    exp_a1 = '0;
    bounce_amp = '0;
    bounce_dly = 8'h01;
    fir_coef = '0;
    fir_coef[0] = 18'h08000;
  endtask : set_unity

  // One word in, wait for it at the sink; flags are gathered meanwhile
  task xfer(input word_t w, output word_t g, output int l);
    int base;
    base = u_dac.rx_count;
    l = 0;
    ar_seen = '0;
    dac_seen = '0;
    in_data = w;
    in_valid = 1'b1;
    while (u_dac.rx_count == base && l < 400)
    begin
      @(negedge mclk);
      if (l == 0)
        in_valid = 1'b0;
      l++;
      if (out_valid === 1'b1)
        dac_seen = dac_ovf;
      ar_seen |= arith_ovf;
    end
    if (l >= 400)
    begin
      bad_count++;
      report_and_stop();
    end
    g = u_dac.rx_mem[base[7:0]];
    l = l - 2;
  endtask : xfer

  task clear_hist(input clear_mode_t m, input logic instr);
    clear_mode = m;
    filter_clear_instruction = instr;
    waveform_playback_instruction = 1'b1;
    @(negedge mclk);
    waveform_playback_instruction = 1'b0;
    repeat (2) @(negedge mclk);
    filter_clear_instruction = 1'b0;
  endtask : clear_hist

  // ****************************************
  // Scenarios
  // ****************************************
  task latency_table;
    for (int i = 0; i < 8; i++)
    begin
      {chain_en, stage_en} = cfg_tab[i];
      xfer(unit_w, got, lat);
      `CHK(lat, lat_tab[i])
      `CHK(got, unit_w)
    end
  endtask : latency_table

  task hp_clear;
    chain_en = 1'b1;
    stage_en = 11'h100;
    iir_b1[`ST_HP] = '0;
    clear_hist(CLR_LEVEL, 1'b1);
    xfer(fill(16'h0100), got, lat);
    `CHK(got, ramp(0))
    xfer(fill(16'h0100), got, lat);
    `CHK(got, ramp(8))
    for (int m = 0; m < 4; m++)
    begin
      clear_hist(clear_mode_t'(m[1:0]), 1'b1);
      xfer(fill(16'h0100), got, lat);
      `CHK(got, ramp(0))
    end
    clear_hist(CLR_BOTH, 1'b0);
    xfer(fill(16'h0100), got, lat);
    `CHK(got, ramp(8))
  endtask : hp_clear

  task other_stages;
    stage_en = 11'h200;
    bounce_amp = 18'h04000;
    clear_hist(CLR_RISE, 1'b1);
    xfer(fill(16'h2000), got, lat);
    `CHK(got, {{7{16'h3000}}, 16'h2000})
    stage_en = 11'h400;
    fir_coef[8] = 18'h04000;
    clear_hist(CLR_FALL, 1'b1);
    xfer({112'h0, 16'h2000}, got, lat);
    `CHK(got, {112'h0, 16'h2000})
    xfer('0, got, lat);
    `CHK(got, {96'h0, 16'h1000, 16'h1000})
    stage_en = 11'h001;
    iir_b0[0] = 18'h04000;
    xfer(fill(16'h2000), got, lat);
    `CHK(got, fill(16'h1000))
    iir_b0[0] = 18'h10000;
    xfer(fill(16'h6000), got, lat);
    `CHK(got, fill(16'h7fff))
    `CHK(dac_seen, 11'h001)
    `CHK(ar_seen, 11'h001)
  endtask : other_stages

  // Sink stalls until the buffer refuses, then drains slowly
  task fifo_run;
    int n;
    int base;
    n = 0;
    chain_en = 1'b0;
    hold = 1'b1;
    repeat (2) @(negedge mclk);
    base = u_dac.rx_count;
    // Offer a word only while ready, so no pending request is withdrawn
    for (int i = 0; i < 20; i++)
    begin
      in_valid = in_ready;
      if (in_ready === 1'b1)
      begin
        in_data = fill(16'(i));
        n++;
      end
      @(negedge mclk);
    end
    in_valid = 1'b0;
    `CHK(n, `FIFO_DEPTH)
    `CHK(in_ready, 1'b0)
    hold = 1'b0;
    slow = 1'b1;
    for (int t = 0; t < 200 && u_dac.rx_count < base + 16; t++)
      @(negedge mclk);
    if (u_dac.rx_count < base + 16)
    begin
      bad_count++;
      report_and_stop();
    end
    repeat (20) @(negedge mclk);
    `CHK(u_dac.rx_count - base, 16)
    for (int i = 0; i < 16; i++)
      `CHK(u_dac.rx_mem[base + i], fill(16'(i)))
  endtask : fifo_run

  initial
  begin
    set_unity();
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    @(negedge mclk);
    `CHK(arith_ovf, 11'h000)
    latency_table();
    hp_clear();
    other_stages();
    fifo_run();
    report_and_stop();
  end
endmodule : precomp_chain_test
